// file: verilog/mpss_pkg.sv
// package of constants, states and carrier structs for the power-state sequencer
package mpss_pkg;

  // clock rate in kHz, so that millisecond figures turn into cycles
  localparam int unsigned CLK_KHZ          = 200000;
  // timing figures in their own unit, as printed
  localparam int unsigned BTN_MIN_MS       = 50;
  localparam int unsigned BTN_OVR_MS       = 4000;
  localparam int unsigned SMB_WAIT_MS      = 25;
  localparam int unsigned RST_HOLD_MIN_MS  = 5;
  localparam int unsigned RST_HOLD_MAX_MS  = 6;
  // derived cycle counts; the hold sits at the least time, which rounds up exactly
  localparam int unsigned BTN_MIN_CYC      = BTN_MIN_MS * CLK_KHZ;
  localparam int unsigned BTN_OVR_CYC      = BTN_OVR_MS * CLK_KHZ;
  localparam int unsigned SMB_WAIT_CYC     = SMB_WAIT_MS * CLK_KHZ;
  localparam int unsigned RST_HOLD_CYC     = RST_HOLD_MIN_MS * CLK_KHZ;

  // counter widths: 800 million cycles fit in 30 bits
  localparam int unsigned CNT_W            = 30;

  // power states of the module
  typedef enum logic [2:0] {
    MPSS_OFF,
    MPSS_SOFT_OFF,
    MPSS_STARTING,
    MPSS_WORKING,
    MPSS_SUSPEND_RAM,
    MPSS_HIBERNATE
  } mpss_state_t;

  // reset-button sequence
  typedef enum logic [1:0] {
    MPSS_RST_IDLE,
    MPSS_RST_WAIT_BUS,
    MPSS_RST_HOLD
  } mpss_rst_t;

  // synchronised carrier pins travel together
  typedef struct packed {
    logic power_button_n;
    logic supply_good_in;
    logic reset_button_n;
  } mpss_pins_t;

  // requests from platform firmware for sleep states
  typedef struct packed {
    logic sleep_ram;
    logic sleep_disk;
    logic sleep_off;
  } mpss_sleep_t;

endpackage

// file: verilog/mpss_sequencer.sv
// power-state sequencer of the module: button timing, power good, reset and supply enable
//
// Behaviour
// - power-on needs button low 50 ms to 4 s
// - button held four seconds forces power off
// - no start while power good stays low
// - power good fall in working goes soft-off
// - reset waits bus idle, at most 25 ms
// - internal reset held between 5 and 6 ms
// - battery alert forces power-on after supply loss
// - atx: button event raises main power
// - atx: supply enable follows suspend-to-ram status
// - standby supports ram, hibernate, soft-off states
// - single supply starts when main power arrives
// - supply enable unused in single supply
// - single supply restarts on button or reconnect
// - single supply enters no suspend state
`timescale 1ns/1ps

module mpss_sequencer
(
  // clock, reset, enable
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  input  wire logic                 clk_en,
  // carrier pins, asynchronous
  input  wire logic                 power_button_n,
  input  wire logic                 supply_good_in,
  input  wire logic                 reset_button_n,
  input  wire logic                 battery_manager_alert_n,
  // supply presence and mode straps
  input  wire logic                 main_power_present,
  input  wire logic                 standby_rail,
  input  wire logic                 atx_mode,
  input  wire logic                 stay_off_after_fail,
  // firmware side, same clock
  input  wire mpss_pkg::mpss_sleep_t sleep_req,
  input  wire logic                 wake_req,
  input  wire logic                 smbus_idle,
  // outputs
  output logic                      suspend_ram_status_n,
  output logic                      main_supply_enable_n,
  output logic                      internal_reset,
  output logic                      module_powered,
  output mpss_pkg::mpss_state_t     power_state
);

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers

  // two-flop chains for the asynchronous pins
  mpss_pkg::mpss_pins_t pins_meta_reg;   // first stage, read only by second
  mpss_pkg::mpss_pins_t pins_sync_reg;   // usable copy
  mpss_pkg::mpss_pins_t pins_prev_reg;   // for edge detection
  logic [1:0]           aux_meta_reg;    // alert and main power, first stage
  logic [1:0]           aux_sync_reg;    // alert and main power, usable
  logic                 main_prev_reg;   // main power seen last cycle
  logic [1:0]           stby_meta_reg;   // standby rail and mode, first stage
  logic [1:0]           stby_sync_reg;   // standby rail and mode, usable
  mpss_pkg::mpss_pins_t pins_now;

  assign pins_now = '{power_button_n, supply_good_in, reset_button_n};

  // reset values assume released button and pulled-up power good
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      pins_meta_reg <= 3'h7;
      pins_sync_reg <= 3'h7;
      pins_prev_reg <= 3'h7;
      aux_meta_reg  <= 2'h1;
      aux_sync_reg  <= 2'h1;
      main_prev_reg <= 1'b0;
      stby_meta_reg <= 2'h0;
      stby_sync_reg <= 2'h0;
    end
    else if (clk_en)
    begin
      pins_meta_reg <= pins_now;
      pins_sync_reg <= pins_meta_reg;
      pins_prev_reg <= pins_sync_reg;
      aux_meta_reg  <= {main_power_present, battery_manager_alert_n};
      aux_sync_reg  <= aux_meta_reg;
      main_prev_reg <= aux_sync_reg[1];
      stby_meta_reg <= {atx_mode, standby_rail};
      stby_sync_reg <= stby_meta_reg;
    end
  end

  // decoded levels and edges
  logic btn_low;
  logic good_hi;
  logic good_fall;
  logic rst_fall;
  logic alert_wired;
  logic main_on;
  logic main_rise;
  logic stby_on;
  logic atx_sel;

  assign btn_low     = ~pins_sync_reg.power_button_n;
  assign good_hi     = pins_sync_reg.supply_good_in;
  assign good_fall   = pins_prev_reg.supply_good_in & ~pins_sync_reg.supply_good_in;
  assign rst_fall    = pins_prev_reg.reset_button_n & ~pins_sync_reg.reset_button_n;
  // an alert line held low by a battery manager marks it present
  assign alert_wired = ~aux_sync_reg[0];
  assign main_on     = aux_sync_reg[1];
  assign main_rise   = aux_sync_reg[1] & ~main_prev_reg;
  assign stby_on     = stby_sync_reg[0];
  assign atx_sel     = stby_sync_reg[1];

  ////////////////////////////////////////////////////////////////////////////
  // power button timing

  logic [mpss_pkg::CNT_W-1:0] btn_cnt_reg;    // cycles the button has been low
  logic [mpss_pkg::CNT_W-1:0] btn_cnt_next;
  logic                       btn_ovr_reg;    // override already fired this press
  logic                       btn_ovr_next;
  logic                       btn_event;      // released inside the valid window
  logic                       btn_override;   // four seconds reached

  // count while pressed; saturates so a stuck button fires the override once
  always_comb
  begin
    btn_cnt_next = btn_cnt_reg;
    btn_ovr_next = btn_ovr_reg;
    btn_event    = 1'b0;
    btn_override = 1'b0;
    if (btn_low)
    begin
      if (btn_cnt_reg < mpss_pkg::CNT_W'(mpss_pkg::BTN_OVR_CYC))
      begin
        btn_cnt_next = btn_cnt_reg + 1'b1;
      end
      else if (!btn_ovr_reg)
      begin
        btn_override = 1'b1;
        btn_ovr_next = 1'b1;
      end
    end
    else
    begin
      // release: event only for 50 ms <= t < 4 s
      btn_event    = (btn_cnt_reg >= mpss_pkg::CNT_W'(mpss_pkg::BTN_MIN_CYC)) &&
                     (btn_cnt_reg <  mpss_pkg::CNT_W'(mpss_pkg::BTN_OVR_CYC));
      btn_cnt_next = '0;
      btn_ovr_next = 1'b0;
    end
  end

  // button counter registers
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      btn_cnt_reg <= '0;
      btn_ovr_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      btn_cnt_reg <= btn_cnt_next;
      btn_ovr_reg <= btn_ovr_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power state machine

  mpss_pkg::mpss_state_t state_reg;
  mpss_pkg::mpss_state_t state_next;
  logic                  lost_reg;    // supply was lost since last working
  logic                  lost_next;

  // sleep states are only legal with a standby rail in atx mode
  function automatic logic sleep_ok(input logic atx, input logic stby);
    sleep_ok = atx & stby;
  endfunction

  // next power state
  always_comb
  begin
    state_next = state_reg;
    lost_next  = lost_reg;
    case (state_reg)
      mpss_pkg::MPSS_OFF:
      begin
        // single supply: connecting main starts at once; the rising edge is
        // only seen here, so waiting for it in soft-off would miss it
        if (!atx_sel && main_rise && good_hi)
        begin
          state_next = mpss_pkg::MPSS_STARTING;
        end
        // mechanical off: wait for any supply to appear
        else if (main_on || stby_on)
        begin
          state_next = mpss_pkg::MPSS_SOFT_OFF;
        end
      end
      mpss_pkg::MPSS_SOFT_OFF:
      begin
        if (!main_on && !stby_on)
        begin
          state_next = mpss_pkg::MPSS_OFF;
        end
        else if (good_hi || atx_sel)
        begin
          // atx: button event starts; power good rises during start
          if (atx_sel && btn_event)
          begin
            state_next = mpss_pkg::MPSS_STARTING;
          end
          // single supply: auto start on main arrival or button
          else if (!atx_sel && good_hi && (btn_event || main_rise))
          begin
            state_next = mpss_pkg::MPSS_STARTING;
          end
          // after supply loss the alert overrides stay-off
          else if (lost_reg && good_hi && (alert_wired || !stay_off_after_fail))
          begin
            state_next = mpss_pkg::MPSS_STARTING;
          end
        end
      end
      mpss_pkg::MPSS_STARTING:
      begin
        // held here while the carrier keeps power good low
        if (btn_override)
        begin
          state_next = mpss_pkg::MPSS_SOFT_OFF;
        end
        else if (good_hi && main_on)
        begin
          state_next = mpss_pkg::MPSS_WORKING;
          lost_next  = 1'b0;
        end
      end
      mpss_pkg::MPSS_WORKING:
      begin
        if (good_fall || !main_on)
        begin
          // power failure goes straight to soft-off
          state_next = mpss_pkg::MPSS_SOFT_OFF;
          lost_next  = 1'b1;
        end
        else if (btn_override)
        begin
          state_next = mpss_pkg::MPSS_SOFT_OFF;
        end
        else if (sleep_req.sleep_off)
        begin
          state_next = mpss_pkg::MPSS_SOFT_OFF;
        end
        else if (sleep_ok(atx_sel, stby_on) && sleep_req.sleep_ram)
        begin
          state_next = mpss_pkg::MPSS_SUSPEND_RAM;
        end
        else if (sleep_ok(atx_sel, stby_on) && sleep_req.sleep_disk)
        begin
          state_next = mpss_pkg::MPSS_HIBERNATE;
        end
      end
      mpss_pkg::MPSS_SUSPEND_RAM,
      mpss_pkg::MPSS_HIBERNATE:
      begin
        // standby loss drops to off; a button event or wake request starts
        if (!stby_on)
        begin
          state_next = mpss_pkg::MPSS_OFF;
        end
        else if (btn_event || wake_req)
        begin
          state_next = mpss_pkg::MPSS_STARTING;
        end
      end
      default:
      begin
        state_next = mpss_pkg::MPSS_OFF;
      end
    endcase
  end

  // state registers; starting from off counts as a supply loss
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state_reg <= mpss_pkg::MPSS_OFF;
      lost_reg  <= 1'b1;
    end
    else if (clk_en)
    begin
      state_reg <= state_next;
      lost_reg  <= lost_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset-button sequence

  mpss_pkg::mpss_rst_t        rs_reg;
  mpss_pkg::mpss_rst_t        rs_next;
  logic [mpss_pkg::CNT_W-1:0] rs_cnt_reg;   // wait or hold cycles
  logic [mpss_pkg::CNT_W-1:0] rs_cnt_next;

  // a press during the hold is ignored; the hold runs its full length
  always_comb
  begin
    rs_next     = rs_reg;
    rs_cnt_next = rs_cnt_reg;
    case (rs_reg)
      mpss_pkg::MPSS_RST_IDLE:
      begin
        if (rst_fall && state_reg == mpss_pkg::MPSS_WORKING)
        begin
          rs_next     = mpss_pkg::MPSS_RST_WAIT_BUS;
          rs_cnt_next = '0;
        end
      end
      mpss_pkg::MPSS_RST_WAIT_BUS:
      begin
        // graceful: bus idle, or forced after 25 ms
        if (smbus_idle || rs_cnt_reg >= mpss_pkg::CNT_W'(mpss_pkg::SMB_WAIT_CYC - 1))
        begin
          rs_next     = mpss_pkg::MPSS_RST_HOLD;
          rs_cnt_next = '0;
        end
        else
        begin
          rs_cnt_next = rs_cnt_reg + 1'b1;
        end
      end
      mpss_pkg::MPSS_RST_HOLD:
      begin
        // fixed 5 ms hold, inside the 5 to 6 ms window
        if (rs_cnt_reg >= mpss_pkg::CNT_W'(mpss_pkg::RST_HOLD_CYC - 1))
        begin
          rs_next     = mpss_pkg::MPSS_RST_IDLE;
          rs_cnt_next = '0;
        end
        else
        begin
          rs_cnt_next = rs_cnt_reg + 1'b1;
        end
      end
      default:
      begin
        rs_next     = mpss_pkg::MPSS_RST_IDLE;
        rs_cnt_next = '0;
      end
    endcase
  end

  // reset sequence registers
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      rs_reg     <= mpss_pkg::MPSS_RST_IDLE;
      rs_cnt_reg <= '0;
    end
    else if (clk_en)
    begin
      rs_reg     <= rs_next;
      rs_cnt_reg <= rs_cnt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  logic out_status_next;
  logic out_enable_next;
  logic out_rst_next;
  logic out_pwr_next;

  // status low only when running; enable copies it in atx, idle high otherwise
  always_comb
  begin
    out_status_next = ~(state_reg == mpss_pkg::MPSS_STARTING ||
                        state_reg == mpss_pkg::MPSS_WORKING);
    out_enable_next = atx_sel ? out_status_next : 1'b1;
    out_rst_next  = (rs_reg == mpss_pkg::MPSS_RST_HOLD) ||
                    (state_reg == mpss_pkg::MPSS_STARTING);
    out_pwr_next  = (state_reg == mpss_pkg::MPSS_WORKING);
  end

  // output registers
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      suspend_ram_status_n <= 1'b0;
      main_supply_enable_n <= 1'b1;
      internal_reset       <= 1'b1;
      module_powered       <= 1'b0;
      power_state          <= mpss_pkg::MPSS_OFF;
    end
    else if (clk_en)
    begin
      suspend_ram_status_n <= out_status_next;
      main_supply_enable_n <= out_enable_next;
      internal_reset       <= out_rst_next;
      module_powered       <= out_pwr_next;
      power_state          <= state_reg;
    end
  end

endmodule

// file: testbench/mpss_carrier_model.sv
// carrier board model: buttons, power good and the two supplies
`timescale 1ns/1ps

module mpss_carrier_model
(
  // commands from the bench
  input  wire logic press,
  input  wire logic reset_press,
  input  wire logic good_cmd,
  input  wire logic vcc_cmd,
  input  wire logic standby_cmd,
  input  wire logic atx,
  // module pins
  input  wire logic main_supply_enable_n,
  output logic      power_button_n,
  output logic      reset_button_n,
  output logic      supply_good_in,
  output logic      standby_rail,
  output logic      main_power_present
);
  // buttons pull the line low for exactly as long as pressed
  assign power_button_n = !press;
  assign reset_button_n = !reset_press;
  // good stays low until the carrier rails are ready
  assign supply_good_in = good_cmd;
  // standby exists only beside an atx supply
  assign standby_rail = atx & standby_cmd;
  // atx: the main rail follows the inverted status copy, so no main power in soft-off
  assign main_power_present = atx ? (vcc_cmd & !main_supply_enable_n) : vcc_cmd;
endmodule

// file: testbench/mpss_sequencer_assertions.sv
// port-level checker of the power-state sequencer
`timescale 1ns/1ps

module mpss_sequencer_chk
(
  // clock and reset
  input wire logic                  core_clk,
  input wire logic                  rst,
  // watched inputs
  input wire logic                  supply_good_in,
  input wire logic                  reset_button_n,
  input wire logic                  atx_mode,
  input wire logic                  smbus_idle,
  // watched outputs
  input wire logic                  suspend_ram_status_n,
  input wire logic                  main_supply_enable_n,
  input wire logic                  internal_reset,
  input wire logic                  module_powered,
  input wire mpss_pkg::mpss_state_t power_state
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic btn_d_reg, btn_d_next; // last reset button level
  logic wait_reg, wait_next;   // press seen, internal reset not yet out
  ////////////////////////////////////////////////////////////
  // a press while powered opens the bus wait until reset goes out
  always_comb
  begin
    btn_d_next = reset_button_n;
    wait_next  = wait_reg;
    if (internal_reset)
      wait_next = 1'h0;
    else if (btn_d_reg && !reset_button_n && module_powered)
      wait_next = 1'h1;
  end
  always_ff @(posedge core_clk)
  begin
    btn_d_reg <= rst ? 1'h1 : btn_d_next;
    wait_reg  <= rst ? 1'h0 : wait_next;
  end
  ////////////////////////////////////////////////////////////
  property p_atx_copy;
    (atx_mode && power_state != mpss_pkg::MPSS_OFF)[*2]
      |-> main_supply_enable_n == suspend_ram_status_n;
  endproperty
  a_atx_copy: assert property (p_atx_copy) else $error("enable not status copy");
  property p_single_unused;
    (!atx_mode)[*4] |-> main_supply_enable_n;
  endproperty
  a_single_unused: assert property (p_single_unused) else $error("enable used");
  // status low only while starting or working; off is the reset image
  property p_status_map;
    power_state != mpss_pkg::MPSS_OFF |-> suspend_ram_status_n ==
      !(power_state inside {mpss_pkg::MPSS_STARTING, mpss_pkg::MPSS_WORKING});
  endproperty
  a_status_map: assert property (p_status_map) else $error("status level wrong");
  // working is entered only from start-up, where main power was waited for
  property p_powered_map;
    module_powered == (power_state == mpss_pkg::MPSS_WORKING) &&
      (!$rose(module_powered) || $past(power_state) == mpss_pkg::MPSS_STARTING);
  endproperty
  a_powered_map: assert property (p_powered_map) else $error("powered vs state");
  // pin low four cycles: synchroniser cannot have let a start through
  property p_good_low;
    (!supply_good_in)[*4] |=> !$rose(module_powered);
  endproperty
  a_good_low: assert property (p_good_low) else $error("start with good low");
  property p_good_fall;
    module_powered && $fell(supply_good_in) |-> ##[1:8] !module_powered;
  endproperty
  a_good_fall: assert property (p_good_fall) else $error("no power fail exit");
  // the bus going idle during the wait lets the reset out within a few cycles
  property p_bus_idle;
    wait_reg && $rose(smbus_idle) |-> ##[1:6] internal_reset;
  endproperty
  a_bus_idle: assert property (p_bus_idle) else $error("idle bus, no reset");
  property p_hold_min;
    $rose(internal_reset) && module_powered |=> internal_reset[*8];
  endproperty
  a_hold_min: assert property (p_hold_min) else $error("reset pulse short");
  property p_no_sleep;
    (!atx_mode)[*4] |->
      !(power_state inside {mpss_pkg::MPSS_SUSPEND_RAM, mpss_pkg::MPSS_HIBERNATE});
  endproperty
  a_no_sleep: assert property (p_no_sleep) else $error("sleep in single supply");
  c_working: cover property ($rose(module_powered));
  c_sleep: cover property (power_state == mpss_pkg::MPSS_SUSPEND_RAM);
  c_hold: cover property ($rose(internal_reset) && module_powered);
endmodule

bind mpss_sequencer mpss_sequencer_chk i_chk
(
  .core_clk(core_clk), .rst(rst), .supply_good_in(supply_good_in),
  .reset_button_n(reset_button_n), .atx_mode(atx_mode), .smbus_idle(smbus_idle),
  .suspend_ram_status_n(suspend_ram_status_n), .main_supply_enable_n(main_supply_enable_n),
  .internal_reset(internal_reset), .module_powered(module_powered), .power_state(power_state)
);

// file: testbench/tb_module_power_state_sequencer.sv
// self-checking bench of the power-state sequencer
`timescale 1ns/1ps

module tb_module_power_state_sequencer;
  logic                  core_clk = 1'h0; // 200 MHz
  logic                  rst = 1'h1;
  logic                  press = 1'h0;    // power button held
  logic                  rpress = 1'h0;   // reset button held
  logic                  good_cmd = 1'h0; // carrier rails ready
  logic                  vcc_cmd = 1'h1;  // main plug in
  logic                  sb_cmd = 1'h1;   // standby plug in
  logic                  atx = 1'h1;
  logic                  alert_n = 1'h1;
  logic                  stay_off = 1'h0;
  logic                  wake_req = 1'h0;
  logic                  smb_idle = 1'h1;
  mpss_pkg::mpss_sleep_t sleep_req = '0;
  logic                  pbn, rbn, sgi, sbr, mpp, srs_n, mse_n, irst, pwr;
  mpss_pkg::mpss_state_t pst;
  logic [13:0]           notes[$]; // {mask, expected}
  logic [13:0]           e;
  event                  look;
  int                    n_fail = 0;
  int                    n_checks = 0;
  int                    cyc = 0;
  int                    i;
  // expected images {state, status_n, enable_n, int reset, powered}
  localparam logic [6:0] ALL = 7'h7F;
  localparam logic [6:0] NOIR = 7'h7D; // internal reset left open
  localparam logic [6:0] IR = 7'h02;
  localparam logic [6:0] W_ATX = {mpss_pkg::MPSS_WORKING, 4'h1};
  localparam logic [6:0] W_ONE = {mpss_pkg::MPSS_WORKING, 4'h5};
  localparam logic [6:0] S_OFF = {mpss_pkg::MPSS_SOFT_OFF, 4'hC};
  mpss_pkg::mpss_state_t sleep_st[3] = '{mpss_pkg::MPSS_SUSPEND_RAM,
                                         mpss_pkg::MPSS_HIBERNATE, mpss_pkg::MPSS_SOFT_OFF};

  always #2.5 core_clk = !core_clk;

  mpss_carrier_model i_carrier
  (
    .press(press), .reset_press(rpress), .good_cmd(good_cmd), .vcc_cmd(vcc_cmd),
    .standby_cmd(sb_cmd), .atx(atx), .main_supply_enable_n(mse_n), .power_button_n(pbn),
    .reset_button_n(rbn), .supply_good_in(sgi), .standby_rail(sbr), .main_power_present(mpp)
  );
  mpss_sequencer i_dut
  (
    .core_clk(core_clk), .rst(rst), .clk_en(1'h1), .power_button_n(pbn),
    .supply_good_in(sgi), .reset_button_n(rbn), .battery_manager_alert_n(alert_n),
    .main_power_present(mpp), .standby_rail(sbr), .atx_mode(atx),
    .stay_off_after_fail(stay_off), .sleep_req(sleep_req), .wake_req(wake_req),
    .smbus_idle(smb_idle), .suspend_ram_status_n(srs_n), .main_supply_enable_n(mse_n),
    .internal_reset(irst), .module_powered(pwr), .power_state(pst)
  );
  ////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [6:0] seen, input logic [6:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH outputs expected %h seen %h", exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic note(input logic [6:0] mask, input logic [6:0] exp);
    notes.push_back({mask, exp});
    ->look;
  endtask
  // bounded wait on powered; a stuck sequencer shows as one mismatch
  task automatic wait_pw(input logic v);
    int k = 0;
    while (pwr !== v && k < 400)
    begin
      tick(1);
      #1; // look once the edge's updates have settled
      k++;
    end
    check({6'h00, pwr}, {6'h00, v});
    tick(2);
  endtask
  // the mode pin changes inside reset while the synchronisers hold their reset values
  task automatic do_reset(input logic mode);
    tick(1);
    rst <= 1'h1;
    atx <= mode;
    tick(8);
    note(ALL, {mpss_pkg::MPSS_OFF, 4'h6});
    rst <= 1'h0;
  endtask
  ////////////////////////////////////////////////////////////
  // compares the oldest note once the outputs have settled
  initial
  forever
  begin
    @(look);
    #1;
    e = notes.pop_front();
    check({pst, srs_n, mse_n, irst, pwr} & e[13:7], e[6:0]);
  end
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      n_fail++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(76));
    do_reset(1'h1);
    tick(500);
    note(NOIR, S_OFF);
    good_cmd <= 1'h1;
    wait_pw(1'h1);
    note(ALL, W_ATX);
    $display("test power good gating done");
    stay_off <= 1'h1;
    good_cmd <= 1'h0;
    wait_pw(1'h0);
    note(NOIR, S_OFF);
    good_cmd <= 1'h1;
    tick(300);
    note(NOIR, S_OFF);
    alert_n <= 1'h0;
    wait_pw(1'h1);
    note(ALL, W_ATX);
    press <= 1'h1;
    tick(100 + $urandom % 2000);
    press <= 1'h0;
    tick(50);
    note(ALL, W_ATX);
    $display("test power fail and short press done");
    for (i = 0; i < 3; i++)
    begin
      sleep_req <= mpss_pkg::mpss_sleep_t'(3'h4 >> i);
      tick(4);
      sleep_req <= '0;
      wait_pw(1'h0);
      note(NOIR, {sleep_st[i], 4'hC});
      if (i < 2)
      begin
        wake_req <= 1'h1;
        tick(2);
        wake_req <= 1'h0;
        wait_pw(1'h1);
      end
    end
    $display("test sleep states done");
    sb_cmd <= 1'h0;
    do_reset(1'h0);
    wait_pw(1'h1);
    note(ALL, W_ONE);
    sleep_req <= mpss_pkg::mpss_sleep_t'(3'h4);
    tick(20);
    sleep_req <= '0;
    note(ALL, W_ONE);
    // no battery manager and stay-off set: only the reconnect itself may start it
    alert_n <= 1'h1;
    vcc_cmd <= 1'h0;
    wait_pw(1'h0);
    vcc_cmd <= 1'h1;
    wait_pw(1'h1);
    $display("test single supply done");
    smb_idle <= 1'h0;
    rpress <= 1'h1;
    tick(200 + $urandom % 800);
    note(IR, 7'h00);
    smb_idle <= 1'h1;
    tick(8);
    rpress <= 1'h0;
    note(IR, IR);
    tick(20000);
    note(IR, IR);
    tick(2);
    $display("test reset button done");
    report_and_stop();
  end
endmodule
